// ---- design/jtd_pkg.sv ----
// Shared constants for the test access port and debug signalling block.
// Assumes the standard four-wire test port and a single core-side clock.
package jtd_pkg;

	// Controller states, coded as in the usual boundary-scan convention.
	typedef enum logic [3:0] {
		ST_TLR = 4'hf,
		ST_RTI = 4'hc,
		ST_SEL_DR = 4'h7,
		ST_CAP_DR = 4'h6,
		ST_SH_DR = 4'h2,
		ST_EX1_DR = 4'h1,
		ST_PA_DR = 4'h3,
		ST_EX2_DR = 4'h0,
		ST_UPD_DR = 4'h5,
		ST_SEL_IR = 4'h4,
		ST_CAP_IR = 4'he,
		ST_SH_IR = 4'ha,
		ST_EX1_IR = 4'h9,
		ST_PA_IR = 4'hb,
		ST_EX2_IR = 4'h8,
		ST_UPD_IR = 4'hd
	} jtd_tap_state_t;

	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] IR_SCAN_N = 4'h2;
	localparam logic [IR_W-1:0] IR_INTEST = 4'hc;
	localparam logic [IR_W-1:0] IR_IDCODE = 4'he;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	localparam int CHAIN_W = 5;
	localparam logic [CHAIN_W-1:0] CHAIN_RESET = 5'h00;
	localparam logic [CHAIN_W-1:0] CHAIN_COMMS = 5'h01;
	localparam logic [CHAIN_W-1:0] CHAIN_DBG = 5'h02;
	localparam logic [CHAIN_W-1:0] CHAIN_BSCAN = 5'h03;

	localparam int ID_W = 32;
	localparam int ID_MARK_BIT = 0;

	// Debug control chain: bit 1 requests debug entry.
	localparam int DBGC_W = 4;
	localparam int DBGC_REQ_BIT = 1;
	localparam logic [DBGC_W-1:0] DBGC_RESET = 4'h0;

	// Number of core-side pins passed through the input synchroniser.
	localparam int PIN_N = 6;
	localparam int SYNC_N = 3;

endpackage

// ---- design/jtd_tap_if.sv ----
// Carrier between the test port top and its controller state machine.
// Assumes both ends sit on the test clock.
`timescale 1ns/1ps
interface jtd_tap_if;
	import jtd_pkg::*;
	logic tms;
	jtd_tap_state_t state;
	modport fsm (
		input tms,
		output state
	);
	modport user (
		output tms,
		input state
	);
endinterface

// ---- design/jtd_tap_fsm.sv ----
// Sixteen-state test access port controller.
// Assumes the test clock and test reset arrive directly from the pins.
`timescale 1ns/1ps
module jtd_tap_fsm
	import jtd_pkg::*;
(
	// Test clock and reset
	input wire logic tck,
	input wire logic test_reset_n,
	// Controller carrier
	jtd_tap_if.fsm tap
);

	jtd_tap_state_t state_ff;
	jtd_tap_state_t nxt_state;

	always_comb begin
		case (state_ff)
			ST_TLR: nxt_state = tap.tms ? ST_TLR : ST_RTI;
			ST_RTI: nxt_state = tap.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: nxt_state = tap.tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: nxt_state = tap.tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: nxt_state = tap.tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: nxt_state = tap.tms ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: nxt_state = tap.tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: nxt_state = tap.tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: nxt_state = tap.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: nxt_state = tap.tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: nxt_state = tap.tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: nxt_state = tap.tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: nxt_state = tap.tms ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: nxt_state = tap.tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: nxt_state = tap.tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: nxt_state = tap.tms ? ST_SEL_DR : ST_RTI;
			default: nxt_state = ST_TLR;
		endcase
	end

	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			state_ff <= ST_TLR;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign tap.state = state_ff;

	// Five ones in a row always bring the controller home.
	tms_home_a: assert property (
		@(posedge tck) disable iff (!test_reset_n)
		tap.tms [*5] |-> ##1 (state_ff == ST_TLR)
	) else $error("five tms ones did not reach reset state");

	idle_step_a: assert property (
		@(posedge tck) disable iff (!test_reset_n)
		(state_ff == ST_TLR) && !tap.tms |=> (state_ff == ST_RTI)
	) else $error("reset state with tms low did not step to idle");

endmodule // jtd_tap_fsm

// ---- design/jtd_debug_port.sv ----
// Test access port and debug signalling for a processor macrocell.
// Assumes the test pins are timed to tck and the core side to clock.
//
// Contract
// - Phase-one shift clock only in chain-3 shift
// - Phase-two shift clock only in chain-3 shift
// - Readable 32-bit identification register with fields
// - State bus shows controller state, rising edge
// - Two non-overlapping phase clocks from test clock
// - Output enable high exactly while driving data
// - Mode select input chooses next state
// - Receive pending while unread data held
// - Transmit empty while transmit buffer empty
// - Acknowledge high while in debug state
// - Internal request combines pin and control bit
// - Request enters debug after current instruction
// - Condition inputs feed watchpoint units 0, 1
// - External watchpoint input signals data hits
// - External breakpoint input marks fetched instructions
// - Executed flag reports previous cycle's execute
// - Chain number updates falling edge, Update-DR
`timescale 1ns/1ps
module jtd_debug_port
	import jtd_pkg::*;
#(
	parameter int COMMS_W = 32
) (
	// Core clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Test port pins
	input wire logic tck,
	input wire logic test_reset_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic serial_out_enable_n,
	// Identification strap
	input wire logic [ID_W-1:0] device_id_value,
	// Controller view and phase clocks
	output logic [3:0] tap_state_bus,
	output logic [CHAIN_W-1:0] selected_chain_number,
	output logic test_clk_phase_one,
	output logic test_clk_phase_two,
	// External boundary scan chain
	output logic scan_shift_clk_phase1,
	output logic scan_shift_clk_phase2,
	input wire logic chain_return_data,
	// Debug pins
	input wire logic debug_features_enable,
	input wire logic external_debug_request,
	input wire logic external_watchpoint,
	input wire logic external_breakpoint,
	input wire logic watch_condition_zero,
	input wire logic watch_condition_one,
	output logic internal_debug_request,
	output logic debug_state_ack,
	output logic instruction_executed,
	output logic comms_rx_pending,
	output logic comms_tx_empty,
	// Core side
	input wire logic core_instr_done,
	input wire logic core_cond_passed,
	input wire logic core_restart,
	input wire logic core_rx_read,
	input wire logic core_tx_write,
	input wire logic [COMMS_W-1:0] core_tx_data,
	output logic [COMMS_W-1:0] core_rx_data,
	output logic core_watch_cond_zero,
	output logic core_watch_cond_one,
	output logic core_watchpoint_hit,
	output logic core_breakpoint_hit
);

	jtd_tap_if tap ();

	assign tap.tms = tms;

	jtd_tap_fsm u_fsm (
		.tck(tck),
		.test_reset_n(test_reset_n),
		.tap(tap)
	);

	// Test clock domain.

	logic [IR_W-1:0] ir_ff;
	logic [IR_W-1:0] ir_sh_ff;
	logic [CHAIN_W-1:0] chain_ff;
	logic [CHAIN_W-1:0] chain_sh_ff;
	logic [ID_W-1:0] id_sh_ff;
	logic [DBGC_W-1:0] dbgc_ff;
	logic [DBGC_W-1:0] dbgc_sh_ff;
	logic [COMMS_W-1:0] com_sh_ff;
	logic [COMMS_W-1:0] com_rx_ff;
	logic [COMMS_W-1:0] core_tx_word_ff;
	logic rx_tgl_ff;
	logic tx_tgl_ff;
	logic bypass_ff;
	logic tdo_ff;
	logic oe_ff;
	logic [2:0] st_s1_ff;
	logic [2:0] st_s2_ff;

	wire in_tlr = (tap.state == ST_TLR);
	wire in_cap_dr = (tap.state == ST_CAP_DR);
	wire in_sh_dr = (tap.state == ST_SH_DR);
	wire in_upd_dr = (tap.state == ST_UPD_DR);
	wire in_cap_ir = (tap.state == ST_CAP_IR);
	wire in_sh_ir = (tap.state == ST_SH_IR);
	wire in_upd_ir = (tap.state == ST_UPD_IR);
	wire sel_id = (ir_ff == IR_IDCODE);
	wire sel_scan = (ir_ff == IR_SCAN_N);
	wire sel_chain = (ir_ff == IR_INTEST) || (ir_ff == IR_EXTEST);
	wire sel_bs = sel_chain && (chain_ff == CHAIN_BSCAN);
	wire sel_dbg = sel_chain && (chain_ff == CHAIN_DBG);
	wire sel_com = sel_chain && (chain_ff == CHAIN_COMMS);
	wire sel_byp = !(sel_id || sel_scan || sel_dbg || sel_com || sel_bs);
	wire bs_shift = in_sh_dr && sel_bs;
	wire tx_full_t = !st_s2_ff[0];
	wire ack_t = st_s2_ff[1];
	wire rxp_t = st_s2_ff[2];
	wire [DBGC_W-1:0] dbg_status = {ack_t, rxp_t, !tx_full_t, 1'b0};
	wire [ID_W-1:0] id_capture = {device_id_value[ID_W-1:1], 1'b1};

	assign tap_state_bus = tap.state;
	assign test_clk_phase_one = tck;
	assign test_clk_phase_two = !tck;
	assign scan_shift_clk_phase1 = test_clk_phase_one && bs_shift;
	assign scan_shift_clk_phase2 = test_clk_phase_two && bs_shift;
	assign selected_chain_number = chain_ff;
	assign tdo = tdo_ff;
	assign serial_out_enable_n = oe_ff;

	// Status from the core domain, two stages before use.
	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			st_s1_ff <= 3'h1;
			st_s2_ff <= 3'h1;
		end else begin
			st_s1_ff <= {comms_rx_pending, debug_state_ack, comms_tx_empty};
			st_s2_ff <= st_s1_ff;
		end
	end

	// capture and shift of data registers
	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			id_sh_ff <= '0;
			chain_sh_ff <= CHAIN_RESET;
			dbgc_sh_ff <= DBGC_RESET;
			com_sh_ff <= '0;
			bypass_ff <= 1'b0;
			ir_sh_ff <= IR_CAPTURE;
		end else if (in_cap_dr) begin
			id_sh_ff <= id_capture;
			chain_sh_ff <= chain_ff;
			dbgc_sh_ff <= dbg_status;
			com_sh_ff <= core_tx_word_ff;
			bypass_ff <= 1'b0;
		end else if (in_sh_dr) begin
			id_sh_ff <= {tdi, id_sh_ff[ID_W-1:1]};
			chain_sh_ff <= {tdi, chain_sh_ff[CHAIN_W-1:1]};
			dbgc_sh_ff <= {tdi, dbgc_sh_ff[DBGC_W-1:1]};
			com_sh_ff <= {tdi, com_sh_ff[COMMS_W-1:1]};
			bypass_ff <= tdi;
		end else if (in_cap_ir) begin
			ir_sh_ff <= IR_CAPTURE;
		end else if (in_sh_ir) begin
			ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]};
		end
	end

	// Reading the transmit word marks it consumed for the core.
	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			tx_tgl_ff <= 1'b0;
		end else if (in_cap_dr && sel_com && tx_full_t) begin
			tx_tgl_ff <= !tx_tgl_ff;
		end
	end

	// Instruction, chain and control update on the falling edge.
	// test reset clears scan state
	always_ff @(negedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			ir_ff <= IR_IDCODE;
			chain_ff <= CHAIN_RESET;
			dbgc_ff <= DBGC_RESET;
		end else if (in_tlr) begin
			ir_ff <= IR_IDCODE;
			chain_ff <= CHAIN_RESET;
			dbgc_ff <= DBGC_RESET;
		end else if (in_upd_ir) begin
			ir_ff <= ir_sh_ff;
		end else if (in_upd_dr && sel_scan) begin
			chain_ff <= chain_sh_ff;
		end else if (in_upd_dr && sel_dbg) begin
			dbgc_ff <= dbgc_sh_ff;
		end
	end

	// The receive word stays still until the next update, long after
	// the core has sampled it behind the toggle.
	always_ff @(negedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			com_rx_ff <= '0;
			rx_tgl_ff <= 1'b0;
		end else if (in_upd_dr && sel_com) begin
			com_rx_ff <= com_sh_ff;
			rx_tgl_ff <= !rx_tgl_ff;
		end
	end

	// Serial output and its enable change on the falling edge.
	always_ff @(negedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			tdo_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= in_sh_dr || in_sh_ir;
			if (in_sh_ir) begin
				tdo_ff <= ir_sh_ff[0];
			end else if (sel_id) begin
				tdo_ff <= id_sh_ff[0];
			end else if (sel_scan) begin
				tdo_ff <= chain_sh_ff[0];
			end else if (sel_dbg) begin
				tdo_ff <= dbgc_sh_ff[0];
			end else if (sel_com) begin
				tdo_ff <= com_sh_ff[0];
			end else if (sel_bs) begin
				tdo_ff <= chain_return_data;
			end else if (sel_byp) begin
				tdo_ff <= bypass_ff;
			end
		end
	end

	// Core clock domain.

	logic [PIN_N-1:0] pin_s1_ff;
	logic [PIN_N-1:0] pin_s2_ff;
	logic [SYNC_N-1:0] tk_s1_ff;
	logic [SYNC_N-1:0] tk_s2_ff;
	logic [1:0] tgl_d_ff;
	logic ack_ff;
	logic exec_ff;
	logic rxp_ff;
	logic txe_ff;
	logic [COMMS_W-1:0] core_rx_word_ff;

	// Every pin passes two stages before any gate reads it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			tk_s1_ff <= '0;
			tk_s2_ff <= '0;
			tgl_d_ff <= '0;
		end else begin
			pin_s1_ff <= {debug_features_enable, external_debug_request,
				external_watchpoint, external_breakpoint,
				watch_condition_one, watch_condition_zero};
			pin_s2_ff <= pin_s1_ff;
			tk_s1_ff <= {dbgc_ff[DBGC_REQ_BIT], tx_tgl_ff, rx_tgl_ff};
			tk_s2_ff <= tk_s1_ff;
			tgl_d_ff <= tk_s2_ff[1:0];
		end
	end

	wire en_s = pin_s2_ff[5];
	wire ext_req_s = pin_s2_ff[4];
	wire ctrl_req_s = tk_s2_ff[2];
	wire rx_evt = tk_s2_ff[0] ^ tgl_d_ff[0];
	wire tx_evt = tk_s2_ff[1] ^ tgl_d_ff[1];
	wire tx_take = core_tx_write && txe_ff;
	wire req_any = en_s && (ext_req_s || ctrl_req_s);
	wire wpt_hit = en_s && pin_s2_ff[3];
	wire bkpt_hit = en_s && pin_s2_ff[2];
	wire enter_dbg = (req_any || wpt_hit || bkpt_hit) && core_instr_done;

	assign internal_debug_request = req_any;
	assign core_watchpoint_hit = wpt_hit;
	assign core_breakpoint_hit = bkpt_hit;
	assign core_watch_cond_zero = pin_s2_ff[0];
	assign core_watch_cond_one = pin_s2_ff[1];
	assign debug_state_ack = ack_ff;
	assign instruction_executed = exec_ff;
	assign comms_rx_pending = rxp_ff;
	assign comms_tx_empty = txe_ff;
	assign core_rx_data = core_rx_word_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else if (enter_dbg) begin
			ack_ff <= 1'b1;
		end else if (core_restart) begin
			ack_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exec_ff <= 1'b0;
		end else begin
			exec_ff <= core_cond_passed && core_instr_done;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxp_ff <= 1'b0;
			core_rx_word_ff <= '0;
		end else if (rx_evt) begin
			rxp_ff <= 1'b1;
			core_rx_word_ff <= com_rx_ff;
		end else if (core_rx_read) begin
			rxp_ff <= 1'b0;
		end
	end

	// empty until core writes
	// A write while full is dropped, so it never races the drain.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txe_ff <= 1'b1;
			core_tx_word_ff <= '0;
		end else if (tx_take) begin
			txe_ff <= 1'b0;
			core_tx_word_ff <= core_tx_data;
		end else if (tx_evt) begin
			txe_ff <= 1'b1;
		end
	end

	// Checks on the test clock side.

	// Each phase is checked at the edge that ends it, where its sampled level is high.
	shift1_gate_a: assert property (
		@(negedge tck) disable iff (!test_reset_n)
		scan_shift_clk_phase1 == (in_sh_dr && (chain_ff == CHAIN_BSCAN) && sel_chain)
	) else $error("phase-one shift clock wrong for state");

	shift2_gate_a: assert property (
		@(posedge tck) disable iff (!test_reset_n)
		scan_shift_clk_phase2 == (in_sh_dr && (chain_ff == CHAIN_BSCAN) && sel_chain)
	) else $error("phase-two shift clock wrong for state");

	phase_split_a: assert property (
		@(negedge tck) disable iff (!test_reset_n)
		test_clk_phase_one && !test_clk_phase_two
	) else $error("phase clocks overlap");

	drive_enable_a: assert property (
		@(posedge tck) disable iff (!test_reset_n)
		serial_out_enable_n == (in_sh_dr || in_sh_ir)
	) else $error("output enable not matching shift state");

	id_capture_a: assert property (
		@(posedge tck) disable iff (!test_reset_n)
		in_cap_dr && sel_id |=> id_sh_ff == {$past(device_id_value[ID_W-1:1]), 1'b1}
	) else $error("identification value not captured");

	chain_update_a: assert property (
		@(negedge tck) disable iff (!test_reset_n)
		in_upd_dr && sel_scan |=> selected_chain_number == $past(chain_sh_ff)
	) else $error("chain number not updated in update state");

	// Checks on the core clock side.

	req_combine_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(external_debug_request && debug_features_enable) [*4] |-> internal_debug_request
	) else $error("held pin request not reaching core");

	dbg_entry_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		internal_debug_request && core_instr_done |=> debug_state_ack
	) else $error("debug entry missed at instruction end");

	exec_flag_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		core_cond_passed && core_instr_done |=> instruction_executed ##1
			(instruction_executed == $past(core_cond_passed && core_instr_done))
	) else $error("executed flag not one cycle late");

	rx_clear_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		core_rx_read && !rx_evt |=> !comms_rx_pending
	) else $error("receive pending stayed after read");

	tx_fill_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		core_tx_write && comms_tx_empty |=> !comms_tx_empty [*2]
	) else $error("transmit empty stayed after write");

endmodule // jtd_debug_port

// ---- sim/jtd_ext_chain.sv ----
// Model of an external boundary scan chain clocked by the two shift clocks.
// Assumes the phase clocks and shift clocks come straight from the device.
`timescale 1ns/1ps
module jtd_ext_chain #(
	parameter int LEN = 8
) (
	// Phase clocks from the device
	input wire logic test_clk_phase_one,
	input wire logic test_clk_phase_two,
	// Shift clocks and serial return
	input wire logic scan_shift_clk_phase1,
	input wire logic scan_shift_clk_phase2,
	output logic chain_return_data
);
	logic [LEN-1:0] cells_ff = {(LEN/2){2'h2}};
	int p1_count = 0;
	int p2_count = 0;
	int overlap_count = 0;
	assign chain_return_data = cells_ff[0];
	// Sampling mid-phase keeps edge glitches out of the counts.
	always @(posedge test_clk_phase_one) begin
		#20;
		if (scan_shift_clk_phase1) begin
			p1_count++;
		end
		if (test_clk_phase_two) begin
			overlap_count++;
		end
	end
	// The slave half moves the chain; the inverted refill keeps the return line changing.
	always @(posedge test_clk_phase_two) begin
		#20;
		if (scan_shift_clk_phase2) begin
			p2_count++;
			cells_ff <= {~cells_ff[0], cells_ff[LEN-1:1]};
		end
	end
endmodule // jtd_ext_chain

// ---- sim/testbench.sv ----
// Self-checking bench for the test port and debug signalling block.
// Assumes the test clock is made here and stands still between scans.
`timescale 1ns/1ps
module testbench;
	import jtd_pkg::*;
	logic clock = 1'h0, rst_n = 1'h1, tck = 1'h0, test_reset_n = 1'h1, tms = 1'h1, tdi = 1'h0;
	logic [31:0] id_strap = 32'h1, core_tx_data = 32'h0, core_rx_data, got, w, rx;
	logic [5:0] pin_v = 6'h20;
	logic [4:0] core_p = 5'h00;
	logic tdo, serial_out_enable_n, test_clk_phase_one, test_clk_phase_two, o;
	logic scan_shift_clk_phase1, scan_shift_clk_phase2, chain_return_data;
	logic internal_debug_request, debug_state_ack, instruction_executed;
	logic comms_rx_pending, comms_tx_empty, core_watch_cond_zero, core_watch_cond_one;
	logic core_watchpoint_hit, core_breakpoint_hit;
	logic [3:0] tap_state_bus;
	logic [4:0] selected_chain_number;
	logic [5:0] pin_tab [7] = '{6'h30, 6'h10, 6'h28, 6'h24, 6'h07, 6'h22, 6'h21};
	logic [4:0] exec_tab [3] = '{5'h18, 5'h10, 5'h08};
	logic [31:0] tx_q [$];
	logic bs_q [$] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
	logic bq;
	int bad_count = 0, cmp_count = 0, c1, c2;
	integer seed = 32'h0d87;
	jtd_tap_state_t exp_st = ST_TLR;

	jtd_debug_port #(.COMMS_W(32)) jtd_debug_port_i (
		.clock, .rst_n, .tck, .test_reset_n, .tms, .tdi, .tdo, .serial_out_enable_n,
		.device_id_value(id_strap), .tap_state_bus, .selected_chain_number,
		.test_clk_phase_one, .test_clk_phase_two, .scan_shift_clk_phase1,
		.scan_shift_clk_phase2, .chain_return_data,
		.debug_features_enable(pin_v[5]), .external_debug_request(pin_v[4]),
		.external_watchpoint(pin_v[3]), .external_breakpoint(pin_v[2]),
		.watch_condition_zero(pin_v[1]), .watch_condition_one(pin_v[0]),
		.internal_debug_request, .debug_state_ack, .instruction_executed,
		.comms_rx_pending, .comms_tx_empty, .core_instr_done(core_p[4]),
		.core_cond_passed(core_p[3]), .core_restart(core_p[2]), .core_rx_read(core_p[1]),
		.core_tx_write(core_p[0]), .core_tx_data, .core_rx_data, .core_watch_cond_zero,
		.core_watch_cond_one, .core_watchpoint_hit, .core_breakpoint_hit
	);
	jtd_ext_chain #(.LEN(8)) jtd_ext_chain_i (
		.test_clk_phase_one, .test_clk_phase_two, .scan_shift_clk_phase1,
		.scan_shift_clk_phase2, .chain_return_data
	);

	always #25 clock = ~clock;

	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic jtd_tap_state_t tap_next(jtd_tap_state_t s, logic m);
		case (s)
			ST_TLR: return m ? ST_TLR : ST_RTI;
			ST_RTI: return m ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: return m ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: return m ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: return m ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: return m ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: return m ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: return m ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: return m ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: return m ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: return m ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: return m ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
			default: return m ? ST_SEL_DR : ST_RTI;
		endcase
	endfunction

	// One test clock period; tms and tdi change in the low phase only.
	task jbit(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		#20;
		chk("tap_state", exp_st, tap_state_bus);
		chk("out_en", exp_st == ST_SH_DR || exp_st == ST_SH_IR, serial_out_enable_n);
		q = tdo;
		tck = 1'h1;
		exp_st = tap_next(exp_st, m);
		#20;
		chk("phase_hi", 2'h2, {test_clk_phase_one, test_clk_phase_two});
		#20;
		tck = 1'h0;
		#20;
		chk("phase_lo", 2'h1, {test_clk_phase_one, test_clk_phase_two});
	endtask

	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = 32'h0;
		jbit(1'h1, 1'h0, q);
		if (ir) begin
			jbit(1'h1, 1'h0, q);
		end
		jbit(1'h0, 1'h0, q);
		jbit(1'h0, 1'h0, q);
		for (int i = 0; i < n; i++) begin
			jbit(i == n - 1, din[i], q);
			dout[i] = q;
		end
		jbit(1'h1, 1'h0, q);
		jbit(1'h0, 1'h0, q);
	endtask

	task sel(input logic [4:0] ch, input logic [3:0] ins);
		logic [31:0] cap;
		scan(1'h1, IR_W, IR_SCAN_N, cap);
		chk("ir_capture", IR_CAPTURE, cap);
		scan(1'h0, CHAIN_W, ch, cap);
		chk("chain_no", ch, selected_chain_number);
		scan(1'h1, IR_W, ins, cap);
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task core_pulse(input logic [4:0] p, input logic [31:0] d);
		@(posedge clock);
		core_p <= p;
		core_tx_data <= d;
		@(posedge clock);
		core_p <= 5'h00;
		#1;
	endtask

	initial begin
		#1000000;
		bad_count++;
		$display("BAD watchdog expected end seen hang");
		tally_and_finish;
	end

	initial begin
		// A real falling edge on both resets, since the test clock stands still during reset.
		rst_n <= 1'h0;
		test_reset_n <= 1'h0;
		id_strap = $random(seed) | 32'h1;
		repeat (8) @(posedge clock);
		rst_n <= 1'h1;
		test_reset_n <= 1'h1;
		cyc(4);
		chk("tx_empty_rst", 1'h1, comms_tx_empty);
		chk("ack_rst", 1'h0, debug_state_ack);
		jbit(1'h0, 1'h0, o);
		scan(1'h0, ID_W, 32'h0, got);
		chk("idcode", id_strap, got);
		scan(1'h1, IR_W, 4'h7, got);
		scan(1'h0, 2, 2'h1, got);
		chk("bypass", 32'h2, got);
		for (int k = 0; k < 2; k++) begin
			sel(CHAIN_BSCAN, k ? IR_INTEST : IR_EXTEST);
			c1 = jtd_ext_chain_i.p1_count;
			c2 = jtd_ext_chain_i.p2_count;
			scan(1'h0, 6 + k, $random(seed), got);
			chk("shift_p1", 6 + k, jtd_ext_chain_i.p1_count - c1);
			chk("shift_p2", 6 + k, jtd_ext_chain_i.p2_count - c2);
			w = 32'h0;
			for (int i = 0; i < 6 + k; i++) begin
				bq = bs_q.pop_front();
				w[i] = bq;
				bs_q.push_back(!bq);
			end
			chk("bs_return", w, got);
		end
		sel(CHAIN_DBG, IR_INTEST);
		c1 = jtd_ext_chain_i.p1_count;
		scan(1'h0, DBGC_W, 4'h2, got);
		chk("dbg_cap", 4'h2, got);
		chk("no_shift", c1, jtd_ext_chain_i.p1_count);
		cyc(6);
		chk("req_ctrl", 1'h1, internal_debug_request);
		core_pulse(5'h10, 32'h0);
		chk("ack_ctrl", 1'h1, debug_state_ack);
		cyc(4);
		scan(1'h0, DBGC_W, 4'h0, got);
		chk("dbg_cap_ack", 4'ha, got);
		cyc(6);
		core_pulse(5'h04, 32'h0);
		chk("ack_off", 1'h0, debug_state_ack);
		chk("req_off", 1'h0, internal_debug_request);
		for (int k = 0; k < 7; k++) begin
			@(posedge clock);
			pin_v <= pin_tab[k];
			cyc(4);
			chk("pin_req", pin_v[5] & pin_v[4], internal_debug_request);
			chk("wpt_hit", pin_v[5] & pin_v[3], core_watchpoint_hit);
			chk("bkpt_hit", pin_v[5] & pin_v[2], core_breakpoint_hit);
			chk("cond0", pin_v[1], core_watch_cond_zero);
			chk("cond1", pin_v[0], core_watch_cond_one);
			core_pulse(5'h10, 32'h0);
			chk("ack_pin", pin_v[5] & (|pin_v[4:2]), debug_state_ack);
			core_pulse(5'h04, 32'h0);
			chk("ack_clr", 1'h0, debug_state_ack);
		end
		for (int k = 0; k < 3; k++) begin
			core_pulse(exec_tab[k], 32'h0);
			chk("executed", k == 0, instruction_executed);
		end
		sel(CHAIN_COMMS, IR_INTEST);
		for (int k = 0; k < 2; k++) begin
			w = $random(seed);
			tx_q.push_back(w);
			core_pulse(5'h01, w);
			chk("tx_full", 1'h0, comms_tx_empty);
			core_pulse(5'h01, ~w);
			rx = $random(seed);
			scan(1'h0, 32, rx, got);
			chk("tx_word", tx_q.pop_front(), got);
			cyc(6);
			chk("tx_empty", 1'h1, comms_tx_empty);
			chk("rx_pend", 1'h1, comms_rx_pending);
			chk("rx_word", rx, core_rx_data);
			core_pulse(5'h02, 32'h0);
			chk("rx_read", 1'h0, comms_rx_pending);
		end
		jbit(1'h1, 1'h0, o);
		jbit(1'h0, 1'h0, o);
		jbit(1'h0, 1'h0, o);
		test_reset_n <= 1'h0;
		#30;
		exp_st = ST_TLR;
		chk("trst_state", ST_TLR, tap_state_bus);
		chk("trst_chain", CHAIN_RESET, selected_chain_number);
		test_reset_n <= 1'h1;
		jbit(1'h0, 1'h0, o);
		jbit(1'h1, 1'h0, o);
		jbit(1'h0, 1'h0, o);
		jbit(1'h0, 1'h0, o);
		repeat (5) jbit(1'h1, 1'h0, o);
		jbit(1'h0, 1'h0, o);
		scan(1'h0, ID_W, 32'h0, got);
		chk("idcode_again", id_strap, got);
		chk("overlap", 32'h0, jtd_ext_chain_i.overlap_count);
		tally_and_finish;
	end
endmodule // testbench
